// ---- inc/rrf_pkg.sv ----
/*
  Shared constants for the return, rotate and flag load execution unit:
  operation codes, flag word bit positions, state encodings and widths.
  Assumes a 16-bit word datapath and a byte-wide memory port.
*/
package rrf_pkg;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int FLAG_W = 16;
   localparam int CNT_W = 8;

   typedef enum logic [2:0] {
      OP_PROC_RETURN = 3'h0,
      OP_ROTATE_LEFT = 3'h1,
      OP_ROTATE_RIGHT = 3'h2,
      OP_FLAGS_FROM_UPPER_ACC = 3'h3
   } op_type;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_POP_LO = 4'h1,
      ST_POP_HI = 4'h2,
      ST_POP_DONE = 4'h3,
      ST_ADJUST = 4'h4,
      ST_MEM_RD = 4'h5,
      ST_MEM_WAIT = 4'h6,
      ST_ROTATE = 4'h7,
      ST_WR_LO = 4'h8,
      ST_WR_HI = 4'h9,
      ST_FINISH = 4'hA
   } state_type;

   // Flag word bit positions.
   localparam int CARRY_BIT = 0;
   localparam int PARITY_BIT = 2;
   localparam int AUX_BIT = 4;
   localparam int ZERO_BIT = 6;
   localparam int SIGN_BIT = 7;
   localparam int TRAP_BIT = 8;
   localparam int INTR_BIT = 9;
   localparam int DIR_BIT = 10;
   localparam int OVF_BIT = 11;

   localparam logic [WORD_W-1:0] POP_STEP = 16'h0002;
   localparam logic [WORD_W-1:0] HI_BYTE_OFS = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
   localparam logic [FLAG_W-1:0] FLAGS_RESET = 16'h0000;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
endpackage

// ---- design/rotate_step.sv ----
/*
  One rotation step on a byte or word operand, combinational.
  Assumes the caller holds the operand in the low bits for byte mode.
*/
`timescale 1ns/1ps
module rotate_step #(
   parameter int W = 16
) (
   input wire logic [W-1:0] value,
   input wire logic is_word,
   input wire logic dir_right,
   output logic [W-1:0] result,
   output logic carry_out
);
   always_comb begin
      result = value;
      carry_out = 1'b0;
      if (dir_right) begin
         carry_out = value[0];
         if (is_word) begin
            result = {value[0], value[W-1:1]};
         end else begin
            result = {value[W-1:W/2], value[0], value[W/2-1:1]};
         end
      end else begin
         if (is_word) begin
            carry_out = value[W-1];
            result = {value[W-2:0], value[W-1]};
         end else begin
            carry_out = value[W/2-1];
            result = {value[W-1:W/2], value[W/2-2:0], value[W/2-1]};
         end
      end
   end
endmodule

// ---- design/return_rotate_flag_load_unit.sv ----
/*
  Execution unit for procedure return, rotate left, rotate right and
  loading flags from the upper accumulator byte.
  Assumes decode presents one operation per START pulse with operands
  stable until DONE, and a byte memory that answers each read after
  MEM_RD with MEM_RVALID, and accepts writes in one cycle.
*/
`timescale 1ns/1ps
module return_rotate_flag_load_unit #(
   parameter int W = rrf_pkg::WORD_W,
   parameter int CW = rrf_pkg::CNT_W
) (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic START,
   input wire rrf_pkg::op_type OP,
   input wire logic FAR_RETURN,
   input wire logic POP_ADJUST_EN,
   input wire logic [7:0] POP_ADJUST_IMM,
   input wire logic IS_WORD,
   input wire logic OPERAND_IN_MEM,
   input wire logic COUNT_FROM_REG,
   input wire logic [CW-1:0] COUNT_IMM,
   input wire logic [7:0] LOW_COUNT_REGISTER,
   input wire logic [W-1:0] REG_OPERAND,
   input wire logic [W-1:0] MEM_OPERAND_ADDR,
   input wire logic [7:0] UPPER_ACCUMULATOR_BYTE,
   input wire logic [W-1:0] STACK_POINTER_IN,
   input wire logic [15:0] FLAGS_IN,
   input wire logic LOAD_FLAGS,
   input wire logic [7:0] MEM_RDATA,
   input wire logic MEM_RVALID,
   output logic BUSY,
   output logic DONE,
   output logic [W-1:0] INSTRUCTION_POINTER,
   output logic IP_LOAD,
   output logic [W-1:0] CODE_SEGMENT,
   output logic CS_LOAD,
   output logic [W-1:0] STACK_POINTER,
   output logic [15:0] FLAGS,
   output logic [W-1:0] REG_RESULT,
   output logic REG_WRITE,
   output logic [W-1:0] MEM_ADDR,
   output logic MEM_RD,
   output logic MEM_WR,
   output logic [7:0] MEM_WDATA
);
   rrf_pkg::state_type state;
   rrf_pkg::op_type op;
   logic far_ret;
   logic adj_en;
   logic [7:0] adj_imm;
   logic is_word;
   logic in_mem;
   logic pop_second;
   logic [CW-1:0] count;
   logic [CW-1:0] remaining;
   logic [W-1:0] operand;
   logic [W-1:0] base_addr;
   logic [7:0] low_byte;
   logic [W-1:0] step_result;
   logic step_carry;
   logic [W-1:0] popped;

   rotate_step #(
      .W(W)
   ) u_step (
      .value(operand),
      .is_word(is_word),
      .dir_right(op == rrf_pkg::OP_ROTATE_RIGHT),
      .result(step_result),
      .carry_out(step_carry)
   );

   assign popped = {MEM_RDATA, low_byte};

   // ==========================================================
   // Sequencer
   // ==========================================================
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         state <= rrf_pkg::ST_IDLE;
         op <= rrf_pkg::OP_PROC_RETURN;
         far_ret <= 1'b0;
         adj_en <= 1'b0;
         adj_imm <= rrf_pkg::BYTE_ZERO;
         is_word <= 1'b0;
         in_mem <= 1'b0;
         pop_second <= 1'b0;
         count <= rrf_pkg::CNT_ZERO;
         remaining <= rrf_pkg::CNT_ZERO;
         operand <= rrf_pkg::WORD_ZERO;
         base_addr <= rrf_pkg::WORD_ZERO;
         low_byte <= rrf_pkg::BYTE_ZERO;
      end else begin
         case (state)
            rrf_pkg::ST_IDLE: begin
               if (START) begin
                  op <= OP;
                  far_ret <= FAR_RETURN;
                  adj_en <= POP_ADJUST_EN;
                  adj_imm <= POP_ADJUST_IMM;
                  is_word <= IS_WORD;
                  in_mem <= OPERAND_IN_MEM;
                  pop_second <= 1'b0;
                  count <= COUNT_FROM_REG ? LOW_COUNT_REGISTER[CW-1:0] : COUNT_IMM;
                  remaining <= COUNT_FROM_REG ? LOW_COUNT_REGISTER[CW-1:0] : COUNT_IMM;
                  operand <= REG_OPERAND;
                  base_addr <= MEM_OPERAND_ADDR;
                  case (OP)
                     rrf_pkg::OP_PROC_RETURN: state <= rrf_pkg::ST_POP_LO;
                     rrf_pkg::OP_FLAGS_FROM_UPPER_ACC: state <= rrf_pkg::ST_FINISH;
                     default: state <= OPERAND_IN_MEM ? rrf_pkg::ST_MEM_RD : rrf_pkg::ST_ROTATE;
                  endcase
               end
            end
            rrf_pkg::ST_POP_LO: begin
               if (MEM_RVALID) begin
                  low_byte <= MEM_RDATA;
                  state <= rrf_pkg::ST_POP_HI;
               end
            end
            rrf_pkg::ST_POP_HI: begin
               if (MEM_RVALID) begin
                  state <= rrf_pkg::ST_POP_DONE;
               end
            end
            rrf_pkg::ST_POP_DONE: begin
               if (far_ret && !pop_second) begin
                  pop_second <= 1'b1;
                  state <= rrf_pkg::ST_POP_LO;
               end else if (adj_en) begin
                  state <= rrf_pkg::ST_ADJUST;
               end else begin
                  state <= rrf_pkg::ST_FINISH;
               end
            end
            rrf_pkg::ST_ADJUST: state <= rrf_pkg::ST_FINISH;
            rrf_pkg::ST_MEM_RD: begin
               if (MEM_RVALID) begin
                  low_byte <= MEM_RDATA;
                  if (is_word) begin
                     state <= rrf_pkg::ST_MEM_WAIT;
                  end else begin
                     operand <= {rrf_pkg::BYTE_ZERO, MEM_RDATA};
                     state <= rrf_pkg::ST_ROTATE;
                  end
               end
            end
            rrf_pkg::ST_MEM_WAIT: begin
               if (MEM_RVALID) begin
                  operand <= popped;
                  state <= rrf_pkg::ST_ROTATE;
               end
            end
            rrf_pkg::ST_ROTATE: begin
               if (remaining == rrf_pkg::CNT_ZERO) begin
                  state <= in_mem ? rrf_pkg::ST_WR_LO : rrf_pkg::ST_FINISH;
               end else begin
                  operand <= step_result;
                  remaining <= remaining - rrf_pkg::CNT_ONE;
               end
            end
            rrf_pkg::ST_WR_LO: state <= is_word ? rrf_pkg::ST_WR_HI : rrf_pkg::ST_FINISH;
            rrf_pkg::ST_WR_HI: state <= rrf_pkg::ST_FINISH;
            rrf_pkg::ST_FINISH: state <= rrf_pkg::ST_IDLE;
            default: state <= rrf_pkg::ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Stack pointer, instruction pointer and code segment
   // ==========================================================
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         STACK_POINTER <= rrf_pkg::WORD_ZERO;
         INSTRUCTION_POINTER <= rrf_pkg::WORD_ZERO;
         CODE_SEGMENT <= rrf_pkg::WORD_ZERO;
         IP_LOAD <= 1'b0;
         CS_LOAD <= 1'b0;
      end else begin
         IP_LOAD <= 1'b0;
         CS_LOAD <= 1'b0;
         if (state == rrf_pkg::ST_IDLE && START) begin
            STACK_POINTER <= STACK_POINTER_IN;
         end
         if (state == rrf_pkg::ST_POP_HI && MEM_RVALID) begin
            STACK_POINTER <= STACK_POINTER + rrf_pkg::POP_STEP;
            if (pop_second) begin
               CODE_SEGMENT <= popped;
               CS_LOAD <= 1'b1;
            end else begin
               INSTRUCTION_POINTER <= popped;
               IP_LOAD <= 1'b1;
            end
         end
         if (state == rrf_pkg::ST_ADJUST) begin
            STACK_POINTER <= STACK_POINTER + {rrf_pkg::BYTE_ZERO, adj_imm};
         end
      end
   end

   // ==========================================================
   // Flags
   // ==========================================================
   // Rotate and flag load write only the listed bits; START or an idle LOAD_FLAGS loads the whole word from FLAGS_IN.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         FLAGS <= rrf_pkg::FLAGS_RESET;
      end else if (LOAD_FLAGS && state == rrf_pkg::ST_IDLE && !START) begin
         FLAGS <= FLAGS_IN;
      end else if (state == rrf_pkg::ST_IDLE && START) begin
         FLAGS <= FLAGS_IN;
      end else if (state == rrf_pkg::ST_ROTATE && remaining != rrf_pkg::CNT_ZERO) begin
         FLAGS[rrf_pkg::CARRY_BIT] <= step_carry;
         if (count == rrf_pkg::CNT_ONE) begin
            if (op == rrf_pkg::OP_ROTATE_LEFT) begin
               FLAGS[rrf_pkg::OVF_BIT] <= is_word ? (step_result[W-1] ^ step_carry)
                  : (step_result[W/2-1] ^ step_carry);
            end else begin
               FLAGS[rrf_pkg::OVF_BIT] <= is_word ? (step_result[W-1] ^ step_result[W-2])
                  : (step_result[W/2-1] ^ step_result[W/2-2]);
            end
         end
      end else if (state == rrf_pkg::ST_FINISH && op == rrf_pkg::OP_FLAGS_FROM_UPPER_ACC) begin
         FLAGS[rrf_pkg::SIGN_BIT] <= UPPER_ACCUMULATOR_BYTE[rrf_pkg::SIGN_BIT];
         FLAGS[rrf_pkg::ZERO_BIT] <= UPPER_ACCUMULATOR_BYTE[rrf_pkg::ZERO_BIT];
         FLAGS[rrf_pkg::AUX_BIT] <= UPPER_ACCUMULATOR_BYTE[rrf_pkg::AUX_BIT];
         FLAGS[rrf_pkg::PARITY_BIT] <= UPPER_ACCUMULATOR_BYTE[rrf_pkg::PARITY_BIT];
         FLAGS[rrf_pkg::CARRY_BIT] <= UPPER_ACCUMULATOR_BYTE[rrf_pkg::CARRY_BIT];
      end
   end

   // ==========================================================
   // Memory port and results
   // ==========================================================
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         MEM_ADDR <= rrf_pkg::WORD_ZERO;
         MEM_RD <= 1'b0;
         MEM_WR <= 1'b0;
         MEM_WDATA <= rrf_pkg::BYTE_ZERO;
         REG_RESULT <= rrf_pkg::WORD_ZERO;
         REG_WRITE <= 1'b0;
         DONE <= 1'b0;
         BUSY <= 1'b0;
      end else begin
         MEM_RD <= 1'b0;
         MEM_WR <= 1'b0;
         REG_WRITE <= 1'b0;
         DONE <= (state == rrf_pkg::ST_FINISH);
         BUSY <= (state != rrf_pkg::ST_IDLE) || START;
         case (state)
            rrf_pkg::ST_IDLE: begin
               if (START && OP == rrf_pkg::OP_PROC_RETURN) begin
                  MEM_ADDR <= STACK_POINTER_IN;
                  MEM_RD <= 1'b1;
               end else if (START && OP != rrf_pkg::OP_FLAGS_FROM_UPPER_ACC && OPERAND_IN_MEM) begin
                  MEM_ADDR <= MEM_OPERAND_ADDR;
                  MEM_RD <= 1'b1;
               end
            end
            rrf_pkg::ST_POP_LO: begin
               if (MEM_RVALID) begin
                  MEM_ADDR <= STACK_POINTER + rrf_pkg::HI_BYTE_OFS;
                  MEM_RD <= 1'b1;
               end
            end
            rrf_pkg::ST_POP_DONE: begin
               if (far_ret && !pop_second) begin
                  MEM_ADDR <= STACK_POINTER;
                  MEM_RD <= 1'b1;
               end
            end
            rrf_pkg::ST_MEM_RD: begin
               if (MEM_RVALID && is_word) begin
                  MEM_ADDR <= base_addr + rrf_pkg::HI_BYTE_OFS;
                  MEM_RD <= 1'b1;
               end
            end
            rrf_pkg::ST_ROTATE: begin
               if (remaining == rrf_pkg::CNT_ZERO) begin
                  if (in_mem) begin
                     MEM_ADDR <= base_addr;
                     MEM_WDATA <= operand[7:0];
                     MEM_WR <= 1'b1;
                  end else begin
                     REG_RESULT <= operand;
                     REG_WRITE <= (count != rrf_pkg::CNT_ZERO);
                  end
               end
            end
            rrf_pkg::ST_WR_LO: begin
               if (is_word) begin
                  MEM_ADDR <= base_addr + rrf_pkg::HI_BYTE_OFS;
                  MEM_WDATA <= operand[W-1:8];
                  MEM_WR <= 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
   end
endmodule

// ---- test/rrf_sva.sv ----
/*
  Port checker for the return, rotate and flag load unit.
  Assumes it is bound to the unit and sees its ports by name.
*/
`timescale 1ns/1ps
module rrf_sva #(
   parameter int W = 16,
   parameter int CW = 8
) (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic START,
   input wire rrf_pkg::op_type OP,
   input wire logic OPERAND_IN_MEM,
   input wire logic COUNT_FROM_REG,
   input wire logic [CW-1:0] COUNT_IMM,
   input wire logic [W-1:0] MEM_OPERAND_ADDR,
   input wire logic [7:0] UPPER_ACCUMULATOR_BYTE,
   input wire logic [W-1:0] STACK_POINTER_IN,
   input wire logic [15:0] FLAGS_IN,
   input wire logic BUSY,
   input wire logic DONE,
   input wire logic IP_LOAD,
   input wire logic CS_LOAD,
   input wire logic [15:0] FLAGS,
   input wire logic REG_WRITE,
   input wire logic [W-1:0] MEM_ADDR,
   input wire logic MEM_RD,
   input wire logic MEM_WR
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   // ==========================================================
   // Operation context captured when a request is taken.
   logic go, ret, ip_seen;
   logic [3:0] rd_n, wr_n;
   logic [W-1:0] sp0, addr0, last;
   assign go = START && !BUSY;
   always_ff @(posedge REF_CLK) begin
      if (SRST || go) begin
         ret <= (OP == rrf_pkg::OP_PROC_RETURN);
         ip_seen <= 1'b0;
         rd_n <= 4'h0;
         wr_n <= 4'h0;
         sp0 <= STACK_POINTER_IN;
         addr0 <= MEM_OPERAND_ADDR;
      end else begin
         if (MEM_RD) rd_n <= rd_n + 4'h1;
         if (MEM_RD) last <= MEM_ADDR;
         if (MEM_WR) wr_n <= wr_n + 4'h1;
         if (IP_LOAD) ip_seen <= 1'b1;
      end
   end
   // ==========================================================
   // Properties.
   sequence s_flag_go;
      go && OP == rrf_pkg::OP_FLAGS_FROM_UPPER_ACC;
   endsequence
   sequence s_reg_rot;
      go && !OPERAND_IN_MEM && !COUNT_FROM_REG &&
         (OP == rrf_pkg::OP_ROTATE_LEFT || OP == rrf_pkg::OP_ROTATE_RIGHT);
   endsequence
   property p_flag_bits;
      s_flag_go |-> ##2 DONE && {FLAGS[7:6], FLAGS[4], FLAGS[2], FLAGS[0]} ==
         {UPPER_ACCUMULATOR_BYTE[7:6], UPPER_ACCUMULATOR_BYTE[4],
          UPPER_ACCUMULATOR_BYTE[2], UPPER_ACCUMULATOR_BYTE[0]};
   endproperty
   a_flag_bits: assert property (p_flag_bits) else $error("flag load bits wrong");
   property p_flag_keep;
      s_flag_go |-> ##2 FLAGS[11:8] == $past(FLAGS_IN[11:8], 2);
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("flag load upper flags");
   property p_rot_one;
      s_reg_rot ##0 COUNT_IMM == 8'h01 |-> ##4 DONE;
   endproperty
   a_rot_one: assert property (p_rot_one) else $error("rotate by one timing");
   property p_rot_zero;
      s_reg_rot ##0 COUNT_IMM == 8'h00 |=> (!REG_WRITE)[*2] ##1
         (DONE && !REG_WRITE && FLAGS == $past(FLAGS_IN, 3));
   endproperty
   a_rot_zero: assert property (p_rot_zero) else $error("zero count changed state");
   property p_pop_lo;
      MEM_RD && ret && !rd_n[0] |-> MEM_ADDR == sp0 + W'(rd_n);
   endproperty
   a_pop_lo: assert property (p_pop_lo) else $error("pop low byte address");
   property p_pop_hi;
      MEM_RD && ret && rd_n[0] |-> MEM_ADDR == last + 16'h0001;
   endproperty
   a_pop_hi: assert property (p_pop_hi) else $error("pop high byte address");
   property p_cs_after_ip;
      CS_LOAD |-> ret && ip_seen;
   endproperty
   a_cs_after_ip: assert property (p_cs_after_ip) else $error("segment before pointer");
   property p_mem_wr;
      MEM_WR && !ret |-> rd_n != 4'h0 && MEM_ADDR == addr0 + W'(wr_n);
   endproperty
   a_mem_wr: assert property (p_mem_wr) else $error("write back address");
endmodule
bind return_rotate_flag_load_unit rrf_sva #(.W(W), .CW(CW)) sva_u (.REF_CLK(REF_CLK),
   .SRST(SRST), .START(START), .OP(OP), .OPERAND_IN_MEM(OPERAND_IN_MEM),
   .COUNT_FROM_REG(COUNT_FROM_REG), .COUNT_IMM(COUNT_IMM), .MEM_OPERAND_ADDR(MEM_OPERAND_ADDR),
   .UPPER_ACCUMULATOR_BYTE(UPPER_ACCUMULATOR_BYTE), .STACK_POINTER_IN(STACK_POINTER_IN),
   .FLAGS_IN(FLAGS_IN), .BUSY(BUSY), .DONE(DONE), .IP_LOAD(IP_LOAD), .CS_LOAD(CS_LOAD),
   .FLAGS(FLAGS), .REG_WRITE(REG_WRITE), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
   .MEM_WR(MEM_WR));

// ---- test/rrf_mem_model.sv ----
/*
  Byte memory on the far side of the unit, holding stack and operands.
  Assumes one read in flight; answers after one cycle or, when slow, four.
*/
`timescale 1ns/1ps
module rrf_mem_model (
   input wire logic clk,
   input wire logic slow,
   input wire logic rd,
   input wire logic wr,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   output logic rvalid,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:65535];
   logic [2:0] wait_n = 3'h0;
   logic pend = 1'b0;
   logic [15:0] a;
   initial rvalid = 1'b0;
   initial rdata = 8'h00;
   // Outside a valid beat the data lines toggle, so stale bytes are never mistaken for answers.
   always @(posedge clk) begin
      rvalid <= 1'b0;
      rdata <= ~rdata;
      if (wr) mem[addr] <= wdata;
      if (rd) begin
         pend <= 1'b1;
         a <= addr;
         wait_n <= slow ? 3'h3 : 3'h0;
      end else if (pend && wait_n == 3'h0) begin
         rvalid <= 1'b1;
         rdata <= mem[a];
         pend <= 1'b0;
      end else if (pend) begin
         wait_n <= wait_n - 3'h1;
      end
   end
endmodule

// ---- test/tb.sv ----
/*
  Self-checking bench for the return, rotate and flag load unit.
  Assumes the checker is bound to the unit and the memory model is beside it.
*/
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0, srst = 1'b1, start = 1'b0, far, adj_en, is_word, in_mem, cnt_reg;
   logic ld_flags, slow, busy, done, ip_ld, cs_ld, reg_wr, rd, wr, rvalid, got_wr;
   rrf_pkg::op_type op;
   logic [7:0] adj, cnt_imm, cnt_low, upper, rdata, wdata;
   logic [15:0] v, a, sp_in, flags_in, ip, cs, sp, flags, reg_res, addr, got_ip, got_cs, got_res;
   logic [15:0] f;
   logic [17:0] e;
   int fails = 0, n_tests = 0, lat, n;
   integer seed = 32'hD78DEAA9;
   always #12.5 clk = ~clk;
   return_rotate_flag_load_unit dut_u (.REF_CLK(clk), .SRST(srst), .START(start), .OP(op),
      .FAR_RETURN(far), .POP_ADJUST_EN(adj_en), .POP_ADJUST_IMM(adj), .IS_WORD(is_word),
      .OPERAND_IN_MEM(in_mem), .COUNT_FROM_REG(cnt_reg), .COUNT_IMM(cnt_imm),
      .LOW_COUNT_REGISTER(cnt_low), .REG_OPERAND(v), .MEM_OPERAND_ADDR(a),
      .UPPER_ACCUMULATOR_BYTE(upper), .STACK_POINTER_IN(sp_in), .FLAGS_IN(flags_in),
      .LOAD_FLAGS(ld_flags), .MEM_RDATA(rdata), .MEM_RVALID(rvalid), .BUSY(busy), .DONE(done),
      .INSTRUCTION_POINTER(ip), .IP_LOAD(ip_ld), .CODE_SEGMENT(cs), .CS_LOAD(cs_ld),
      .STACK_POINTER(sp), .FLAGS(flags), .REG_RESULT(reg_res), .REG_WRITE(reg_wr),
      .MEM_ADDR(addr), .MEM_RD(rd), .MEM_WR(wr), .MEM_WDATA(wdata));
   rrf_mem_model mem_u (.clk(clk), .slow(slow), .rd(rd), .wr(wr), .addr(addr), .wdata(wdata),
      .rvalid(rvalid), .rdata(rdata));
   always @(posedge clk) begin
      if (ip_ld) got_ip <= ip;
      if (cs_ld) got_cs <= cs;
      if (reg_wr) got_res <= reg_res;
      if (reg_wr) got_wr <= 1'b1;
   end
   // ==========================================================
   // Shared tasks and expectations.
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic run();
      got_wr = 1'b0;
      slow = 1'($random(seed));
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      check(16'(busy), 16'h0001, "busy after start");
      lat = 1;
      while (done !== 1'b1 && lat < 200) begin
         @(negedge clk);
         lat++;
      end
      if (lat >= 200) check(16'h0000, 16'h0001, "no completion");
      @(negedge clk);
      check(16'(busy), 16'h0000, "busy after done");
   endtask
   // Returns overflow, carry and the rotated value; byte mode keeps bits 15:8.
   function automatic logic [17:0] rot(input logic [15:0] x, input logic w, input logic r,
         input int k, input logic [15:0] fl);
      logic c, o;
      c = fl[0];
      o = fl[11];
      for (int i = 0; i < k; i++) begin
         if (w) x = r ? {x[0], x[15:1]} : {x[14:0], x[15]};
         else x[7:0] = r ? {x[0], x[7:1]} : {x[6:0], x[7]};
         c = r ? (w ? x[15] : x[7]) : x[0];
         o = r ? (w ? x[15] ^ x[14] : x[7] ^ x[6]) : ((w ? x[15] : x[7]) ^ c);
      end
      return {o, c, x};
   endfunction
   // ==========================================================
   // Scenarios.
   initial begin
      {far, adj_en, is_word, in_mem, cnt_reg, ld_flags, slow} = 7'h00;
      {adj, cnt_imm, cnt_low, upper} = 32'h00000000;
      {v, a, sp_in, flags_in} = 64'h0000000000000000;
      op = rrf_pkg::OP_PROC_RETURN;
      repeat (20) @(negedge clk);
      srst = 1'b0;
      for (int i = 0; i < 6; i++) begin
         op = rrf_pkg::OP_FLAGS_FROM_UPPER_ACC;
         upper = 8'($random(seed));
         flags_in = 16'($random(seed));
         run();
         f = flags_in;
         {f[7:6], f[4], f[2], f[0]} = {upper[7:6], upper[4], upper[2], upper[0]};
         check(flags, f, "flag load");
         check(16'(lat), 16'h0002, "flag load latency");
         ld_flags = 1'b1;
         flags_in = 16'($random(seed));
         repeat (2) @(negedge clk);
         ld_flags = 1'b0;
         check(flags, flags_in, "idle flag load");
      end
      $display("flag load test done");
      for (int i = 0; i < 40; i++) begin
         op = i[0] ? rrf_pkg::OP_ROTATE_RIGHT : rrf_pkg::OP_ROTATE_LEFT;
         {in_mem, cnt_reg, is_word} = 3'(i >> 1);
         n = (i % 3 == 0) ? 1 : (i % 5 == 0) ? 0 : ($random(seed) & 19);
         cnt_imm = cnt_reg ? 8'($random(seed)) : 8'(n);
         cnt_low = cnt_reg ? 8'(n) : 8'($random(seed));
         v = 16'($random(seed));
         a = 16'($random(seed));
         flags_in = 16'($random(seed));
         mem_u.mem[a] = v[7:0];
         mem_u.mem[a + 16'h0001] = v[15:8];
         run();
         e = rot(v, is_word, op == rrf_pkg::OP_ROTATE_RIGHT, n, flags_in);
         f = flags_in;
         f[0] = e[16];
         f[11] = (n <= 1) ? e[17] : flags_in[11];
         check(flags, f, "rotate flags");
         if (in_mem) check({mem_u.mem[a + 16'h0001], mem_u.mem[a]}, e[15:0], "memory");
         if (!in_mem && n != 0) check(got_res, e[15:0], "register result");
         if (!in_mem) check(16'(got_wr), 16'(n != 0), "register write");
         if (!in_mem) check(16'(lat), 16'(n + 3), "rotate latency");
      end
      $display("rotate test done");
      for (int i = 0; i < 8; i++) begin
         op = rrf_pkg::OP_PROC_RETURN;
         {adj_en, far} = 2'(i);
         adj = (i == 3) ? 8'hFF : 8'($random(seed));
         sp_in = (i == 7) ? 16'hFFFE : 16'($random(seed));
         flags_in = 16'($random(seed));
         v = 16'($random(seed));
         a = 16'($random(seed));
         {mem_u.mem[sp_in + 16'h0001], mem_u.mem[sp_in]} = v;
         {mem_u.mem[sp_in + 16'h0003], mem_u.mem[sp_in + 16'h0002]} = a;
         run();
         check(got_ip, v, "return pointer");
         if (far) check(got_cs, a, "return segment");
         f = sp_in + (far ? 16'h0004 : 16'h0002) + (adj_en ? {8'h00, adj} : 16'h0000);
         check(sp, f, "stack pointer");
         check(flags, flags_in, "return flags");
      end
      $display("return test done");
      end_sim();
   end
   initial begin
      #(25 * 20000);
      fails++;
      $display("ERROR %0t watchdog expired", $time);
      end_sim();
   end
endmodule
